// ### design/jfc_ctl_status.sv
// Test-port flash control and status word, upper field, with its shift stage
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// (RULE1) Write into full buffer sets data-loss
// (RULE2) Shifted one at bit 4 clears data-loss
// (RULE3) Data-loss clear ignored while busy
// (RULE4) Access flag mirrors protection state
// (RULE5) Blank flag set while core held
// (RULE6) Programming gated by program enable
// (RULE7) Page erase gated by its enable
// (RULE8) Sector erase gated by its enable
// (RULE9) Special erase gated by its enable
// (RULE10) Verify disable skips post-operation verify
// (RULE11) Interface off: writes of one ignored
// (RULE12) Interface off: error flags held clear
// (RULE13) Interface off: other transactions ignored
// (RULE14) Control bits and data-loss reset zero
// (RULE15) Bits 11 to 13 have no function
// (RULE16) Capture loads status, update loads control
// (RULE17) Only power-up and tap reset clear
// (RULE18) Busy while clocks unready or operating
// (RULE19) Reserved read zero, update ignored
module jfc_ctl_status
    import jfc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Test-port side, inputs all asynchronous to clk_sys; tdo leaves a clk_sys flop
    input  wire logic       tck,
    input  wire logic       tdi,
    input  wire logic       chainSelect,
    input  wire logic       captureDr,
    input  wire logic       shiftDr,
    input  wire logic       updateDr,
    input  wire logic       tapReset,
    output logic            tdo,
    // Flash side, same clock domain
    input  wire logic [3:0] lowerStatus,
    input  wire logic       clocksNotReady,
    input  wire logic       flashOperating,
    input  wire logic       fullBufferWrite,
    input  wire logic       protectionActive,
    input  wire logic       coreHeldInReset,
    input  wire logic       programReq,
    input  wire logic       pageEraseReq,
    input  wire logic       sectorEraseReq,
    input  wire logic       specialEraseReq,
    output logic            programGo,
    output logic            pageEraseGo,
    output logic            sectorEraseGo,
    output logic            specialEraseGo,
    output logic            verifyStep,
    output logic            otherTxnEnable,
    output logic            flash_busy_flag,
    output logic            access_enabled_flag,
    output logic            blank_flash_flag,
    output logic            data_loss_err,
    output logic            program_enable,
    output logic            page_erase_enable,
    output logic            sector_erase_enable,
    output logic            special_erase_enable,
    output logic            verify_disable,
    output logic            jtag_flash_if_enable
);

    // ==============================================================
    // State
    typedef struct packed {
        logic [CS_WIDTH-1:0] shiftReg;
        logic                tckPrev;
        logic                dataLoss;
        logic                progEn;
        logic                pageEn;
        logic                sectEn;
        logic                specEn;
        logic                vrfDis;
        logic                ifEn;
        logic                busyFlag;
        logic                accessFlag;
        logic                blankFlag;
    } jfc_state_type;

    jfc_state_type state_ff;
    jfc_state_type nxt_state;

    logic [SI_COUNT-1:0] tapRaw;
    logic [SI_COUNT-1:0] tapSync;
    logic                busy;
    logic                accessOk;
    logic [CS_WIDTH-1:0] statusView;

    // ==============================================================
    // Synchronise the test-port signals
    assign tapRaw[SI_TCK]       = tck;
    assign tapRaw[SI_TDI]       = tdi;
    assign tapRaw[SI_SELECT]    = chainSelect;
    assign tapRaw[SI_CAPTURE]   = captureDr;
    assign tapRaw[SI_SHIFT]     = shiftDr;
    assign tapRaw[SI_UPDATE]    = updateDr;
    assign tapRaw[SI_TAP_RESET] = tapReset;

    jfc_sync #(
        .WIDTH (SI_COUNT)
    ) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .asyncIn (tapRaw),
        .syncOut (tapSync)
    );

    // ==============================================================
    // Status view
    assign busy     = clocksNotReady | flashOperating; // RULE18
    assign accessOk = ~protectionActive; // RULE4

    always_comb begin
        statusView                            = {12'h000, lowerStatus};
        statusView[BIT_BUSY]                  = busy;
        statusView[BIT_DATA_LOSS]             = state_ff.dataLoss;
        statusView[BIT_ACCESS]                = accessOk; // RULE4
        statusView[BIT_BLANK]                 = coreHeldInReset; // RULE5
        statusView[BIT_PROG_EN]               = state_ff.progEn;
        statusView[BIT_PAGE_EN]               = state_ff.pageEn;
        statusView[BIT_SECT_EN]               = state_ff.sectEn;
        statusView[BIT_SPEC_EN]               = state_ff.specEn;
        statusView[BIT_RSV_HI:BIT_RSV_LO]     = 3'h0; // RULE15 RULE19
        statusView[BIT_VRF_DIS]               = state_ff.vrfDis;
        statusView[BIT_IF_EN]                 = state_ff.ifEn;
    end

    // ==============================================================
    // Next state
    logic tckRise;
    logic act;
    logic [CS_WIDTH-1:0] sh;

    always_comb begin
        nxt_state         = state_ff;
        tckRise           = tapSync[SI_TCK] & ~state_ff.tckPrev;
        act               = tckRise & tapSync[SI_SELECT];
        sh                = state_ff.shiftReg;
        nxt_state.tckPrev = tapSync[SI_TCK];

        // Flags lag their sources one cycle so every flag output leaves a flop
        nxt_state.busyFlag   = busy; // RULE18
        nxt_state.accessFlag = accessOk; // RULE4
        nxt_state.blankFlag  = coreHeldInReset; // RULE5

        if (act && tapSync[SI_CAPTURE]) begin
            nxt_state.shiftReg = statusView; // RULE16
        end else if (act && tapSync[SI_SHIFT]) begin
            nxt_state.shiftReg = {tapSync[SI_TDI], sh[CS_WIDTH-1:1]};
        end

        if (act && tapSync[SI_UPDATE]) begin
            // A disabled interface only lets ones fall to zero
            if (state_ff.ifEn) begin
                nxt_state.progEn = sh[BIT_PROG_EN];
                nxt_state.pageEn = sh[BIT_PAGE_EN];
                nxt_state.sectEn = sh[BIT_SECT_EN];
                nxt_state.specEn = sh[BIT_SPEC_EN];
                nxt_state.vrfDis = sh[BIT_VRF_DIS];
            end else begin
                nxt_state.progEn = state_ff.progEn & sh[BIT_PROG_EN]; // RULE11
                nxt_state.pageEn = state_ff.pageEn & sh[BIT_PAGE_EN]; // RULE11
                nxt_state.sectEn = state_ff.sectEn & sh[BIT_SECT_EN]; // RULE11
                nxt_state.specEn = state_ff.specEn & sh[BIT_SPEC_EN]; // RULE11
                nxt_state.vrfDis = state_ff.vrfDis & sh[BIT_VRF_DIS]; // RULE11
            end
            nxt_state.ifEn = sh[BIT_IF_EN]; // RULE16
            if (sh[BIT_DATA_LOSS] && !busy && state_ff.ifEn) begin
                nxt_state.dataLoss = 1'b0; // RULE2 RULE3
            end
        end

        // Set wins over an update clear in the same cycle
        if (fullBufferWrite && state_ff.ifEn) begin
            nxt_state.dataLoss = 1'b1; // RULE1
        end
        if (!state_ff.ifEn) begin
            nxt_state.dataLoss = 1'b0; // RULE12
        end

        if (tapSync[SI_TAP_RESET]) begin
            nxt_state.progEn   = RST_CTRL_BIT; // RULE17
            nxt_state.pageEn   = RST_CTRL_BIT;
            nxt_state.sectEn   = RST_CTRL_BIT;
            nxt_state.specEn   = RST_CTRL_BIT;
            nxt_state.vrfDis   = RST_CTRL_BIT;
            nxt_state.ifEn     = RST_CTRL_BIT;
            nxt_state.dataLoss = RST_DATA_LOSS;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_ff.shiftReg <= RST_SHIFT; // RULE14
            state_ff.tckPrev  <= RST_SYNC_BIT;
            state_ff.dataLoss <= RST_DATA_LOSS;
            state_ff.progEn   <= RST_CTRL_BIT;
            state_ff.pageEn   <= RST_CTRL_BIT;
            state_ff.sectEn   <= RST_CTRL_BIT;
            state_ff.specEn   <= RST_CTRL_BIT;
            state_ff.vrfDis   <= RST_CTRL_BIT;
            state_ff.ifEn     <= RST_CTRL_BIT;
            state_ff.busyFlag   <= RST_FLAG_BIT;
            state_ff.accessFlag <= RST_FLAG_BIT;
            state_ff.blankFlag  <= RST_FLAG_BIT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==============================================================
    // Outputs
    assign tdo = state_ff.shiftReg[0];

    // Grants are combinational so a request is never delayed a cycle
    assign programGo      = programReq & state_ff.progEn & state_ff.ifEn & accessOk; // RULE6
    assign pageEraseGo    = pageEraseReq & state_ff.pageEn & state_ff.ifEn & accessOk; // RULE7
    assign sectorEraseGo  = sectorEraseReq & state_ff.sectEn & state_ff.ifEn & accessOk; // RULE8
    // Special erase is still allowed under protection
    assign specialEraseGo = specialEraseReq & state_ff.specEn & state_ff.ifEn; // RULE9
    assign verifyStep     = ~state_ff.vrfDis; // RULE10
    assign otherTxnEnable = state_ff.ifEn; // RULE13

    assign flash_busy_flag      = state_ff.busyFlag;
    assign access_enabled_flag  = state_ff.accessFlag;
    assign blank_flash_flag     = state_ff.blankFlag;
    assign data_loss_err        = state_ff.dataLoss;
    assign program_enable       = state_ff.progEn;
    assign page_erase_enable    = state_ff.pageEn;
    assign sector_erase_enable  = state_ff.sectEn;
    assign special_erase_enable = state_ff.specEn;
    assign verify_disable       = state_ff.vrfDis;
    assign jtag_flash_if_enable = state_ff.ifEn;

endmodule

`default_nettype wire

// ### design/jfc_pkg.sv
// Field layout and reset values of the flash test-port control and status word
package jfc_pkg;

    // ==============================================================
    // Word geometry
    localparam int unsigned CS_WIDTH      = 16;
    localparam int unsigned SYNC_STAGES   = 2;

    // ==============================================================
    // Bit positions
    localparam int unsigned BIT_BUSY      = 2;
    localparam int unsigned BIT_DATA_LOSS = 4;
    localparam int unsigned BIT_ACCESS    = 5;
    localparam int unsigned BIT_BLANK     = 6;
    localparam int unsigned BIT_PROG_EN   = 7;
    localparam int unsigned BIT_PAGE_EN   = 8;
    localparam int unsigned BIT_SECT_EN   = 9;
    localparam int unsigned BIT_SPEC_EN   = 10;
    localparam int unsigned BIT_RSV_LO    = 11;
    localparam int unsigned BIT_RSV_HI    = 13;
    localparam int unsigned BIT_VRF_DIS   = 14;
    localparam int unsigned BIT_IF_EN     = 15;

    // ==============================================================
    // Values after reset
    localparam logic [15:0] RST_SHIFT     = 16'h0000;
    localparam logic        RST_CTRL_BIT  = 1'b0;
    localparam logic        RST_DATA_LOSS = 1'b0;
    localparam logic        RST_SYNC_BIT  = 1'b0;
    localparam logic        RST_FLAG_BIT  = 1'b0;

    // Order of the synchronised test-port inputs
    localparam int unsigned SI_TCK        = 0;
    localparam int unsigned SI_TDI        = 1;
    localparam int unsigned SI_SELECT     = 2;
    localparam int unsigned SI_CAPTURE    = 3;
    localparam int unsigned SI_SHIFT      = 4;
    localparam int unsigned SI_UPDATE     = 5;
    localparam int unsigned SI_TAP_RESET  = 6;
    localparam int unsigned SI_COUNT      = 7;

endpackage

// ### design/jfc_sync.sv
// Two-stage synchroniser bank for inputs from outside the system clock domain
`timescale 1ns/1ns
`default_nettype none

module jfc_sync
    import jfc_pkg::*;
#(
    parameter int unsigned WIDTH = SI_COUNT
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    // ==============================================================
    // Per-bit flop pairs; first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic stage1_ff;
            logic stage2_ff;
            always_ff @(posedge clk_sys) begin
                if (!nrst) begin
                    stage1_ff <= RST_SYNC_BIT;
                    stage2_ff <= RST_SYNC_BIT;
                end else begin
                    stage1_ff <= asyncIn[gi];
                    stage2_ff <= stage1_ff;
                end
            end
            assign syncOut[gi] = stage2_ff;
        end
    endgenerate

endmodule

`default_nettype wire

// ### tb/jfc_ctl_status_bench.sv
// Self-checking bench for the control and status word
`timescale 1ns/1ns
`default_nettype none
module jfc_ctl_status_bench;
    import jfc_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, tapReset = 1'b0, fullBufferWrite = 1'b0, tdo;
    logic tck, tdi, chainSelect, captureDr, shiftDr, updateDr, verifyStep, otherTxnEnable;
    logic [3:0] lowerStatus = 4'h0;
    logic clocksNotReady = 1'b0, flashOperating = 1'b0, protectionActive = 1'b0;
    logic coreHeldInReset = 1'b0, programReq = 1'b0, pageEraseReq = 1'b0;
    logic sectorEraseReq = 1'b0, specialEraseReq = 1'b0;
    logic programGo, pageEraseGo, sectorEraseGo, specialEraseGo, flash_busy_flag;
    logic access_enabled_flag, blank_flash_flag, data_loss_err, program_enable;
    logic page_erase_enable, sector_erase_enable, special_erase_enable;
    logic verify_disable, jtag_flash_if_enable, loss;
    logic [15:0] ctrl, cap, w;
    logic [15:0] corner [4] = '{16'h7FF0, 16'hFFFF, 16'hFFFF, 16'h8010};
    integer seed = 32'hB1F9;
    integer r;
    int fail_count = 0, n_compared = 0;
    jfc_ctl_status u_dut (.*);
    jfc_host u_host (.*);
    always #4 clk_sys = ~clk_sys;
    // ====
    // Checking and expectation
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [15:0] exp_status();
        return {ctrl[15:14], 3'h0, ctrl[10:7], coreHeldInReset, !protectionActive, loss,
                lowerStatus[3], clocksNotReady | flashOperating, lowerStatus[1:0]};
    endfunction
    task automatic check_ports();
        check("ctrl", {jtag_flash_if_enable, verify_disable, 3'h0, special_erase_enable,
              sector_erase_enable, page_erase_enable, program_enable, 7'h00}, ctrl);
        check("loss", {15'h0, data_loss_err}, {15'h0, loss});
        check("verify", {15'h0, verifyStep}, {15'h0, !ctrl[14]});
        check("txn", {15'h0, otherTxnEnable}, {15'h0, ctrl[15]});
    endtask
    task automatic do_scan(input logic [15:0] v);
        u_host.scan(v, cap);
        check("status", cap, exp_status());
        if (v[4] && !(clocksNotReady | flashOperating)) loss = 1'b0;
        ctrl = (ctrl[15] ? v : ctrl & v) & 16'h4780;
        ctrl[15] = v[15];
        loss = loss & ctrl[15];
        check_ports();
    endtask
    task automatic end_sim();
        $display("Compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end
    initial begin
        ctrl = 16'h0;
        loss = 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            r = $random(seed);
            w = (n < 4) ? corner[n] : r[31:16];
            @(posedge clk_sys);
            {lowerStatus, clocksNotReady, flashOperating, protectionActive, coreHeldInReset} <= r[7:0];
            fullBufferWrite <= r[8];
            {programReq, pageEraseReq, sectorEraseReq, specialEraseReq} <= r[12:9];
            @(posedge clk_sys);
            fullBufferWrite <= 1'b0;
            if (r[8] && ctrl[15]) loss = 1'b1;
            do_scan(w);
            #1;
            check("grant", {12'h0, programGo, pageEraseGo, sectorEraseGo, specialEraseGo},
                {12'h0, {programReq & ctrl[7], pageEraseReq & ctrl[8], sectorEraseReq & ctrl[9]}
                & {3{!protectionActive && ctrl[15]}},
                specialEraseReq & ctrl[10] & ctrl[15]});
        end
        do_scan(16'hFFFF);
        @(posedge clk_sys);
        tapReset <= 1'b1;
        repeat (6) @(posedge clk_sys);
        tapReset <= 1'b0;
        ctrl = 16'h0;
        loss = 1'b0;
        repeat (4) @(posedge clk_sys);
        check_ports();
        do_scan(16'h8000);
        do_scan(16'hC780);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        ctrl = 16'h0;
        loss = 1'b0;
        @(posedge clk_sys);
        check_ports();
        do_scan(16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire

// ### tb/jfc_ctl_status_props.sv
// Concurrent checks on the control and status word ports
`timescale 1ns/1ns
`default_nettype none
module jfc_ctl_status_props (
    input wire logic clk_sys, nrst, updateDr, fullBufferWrite, protectionActive,
    input wire logic coreHeldInReset, clocksNotReady, flashOperating, verifyStep,
    input wire logic programReq, pageEraseReq, sectorEraseReq, specialEraseReq,
    input wire logic programGo, pageEraseGo, sectorEraseGo, specialEraseGo,
    input wire logic flash_busy_flag, access_enabled_flag, blank_flash_flag,
    input wire logic data_loss_err, program_enable, page_erase_enable,
    input wire logic sector_erase_enable, special_erase_enable, verify_disable,
    input wire logic jtag_flash_if_enable
);
    // ====
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    chk_busy_flag: assert property ($past(nrst) |->
        flash_busy_flag == $past(clocksNotReady || flashOperating))
        else $error("busy flag wrong");
    chk_access_flag: assert property ($past(nrst) |->
        access_enabled_flag == !$past(protectionActive))
        else $error("access flag wrong");
    chk_blank_flag: assert property ($past(nrst) |->
        blank_flash_flag == $past(coreHeldInReset))
        else $error("blank flag wrong");
    chk_prog_gate: assert property (programGo == (programReq && program_enable
        && jtag_flash_if_enable && !protectionActive))
        else $error("program grant wrong");
    chk_page_gate: assert property (pageEraseGo == (pageEraseReq && page_erase_enable
        && jtag_flash_if_enable && !protectionActive))
        else $error("page grant wrong");
    chk_sect_gate: assert property (sectorEraseGo == (sectorEraseReq && sector_erase_enable
        && jtag_flash_if_enable && !protectionActive))
        else $error("sector grant wrong");
    chk_spec_gate: assert property (specialEraseGo == (specialEraseReq
        && special_erase_enable && jtag_flash_if_enable))
        else $error("special grant wrong");
    chk_verify_step: assert property (verifyStep != verify_disable)
        else $error("verify step wrong");
    chk_off_clear: assert property (!jtag_flash_if_enable ##1 !jtag_flash_if_enable |-> !data_loss_err)
        else $error("loss flag kept while off");
    chk_loss_set: assert property (fullBufferWrite && jtag_flash_if_enable ##1 jtag_flash_if_enable |-> data_loss_err)
        else $error("loss flag not set");
    chk_update_only: assert property ($rose(verify_disable) |-> $past(updateDr, 2))
        else $error("control changed outside update");
    chk_reset_zero: assert property ($rose(nrst) |-> !(jtag_flash_if_enable || verify_disable || program_enable || data_loss_err))
        else $error("control not zero after reset");
    cover property ($rose(data_loss_err));
    cover property ($fell(data_loss_err) && jtag_flash_if_enable);
    cover property (specialEraseGo && protectionActive);
endmodule
bind jfc_ctl_status jfc_ctl_status_props u_props (.*);
`default_nettype wire

// ### tb/jfc_host.sv
// Test-port host model driving capture, shift and update scans
`timescale 1ns/1ns
`default_nettype none
module jfc_host (
    input  wire logic clk_sys,
    input  wire logic tdo,
    output logic      tck,
    output logic      tdi,
    output logic      chainSelect,
    output logic      captureDr,
    output logic      shiftDr,
    output logic      updateDr
);
    // ====
    // Scan steps; tck stands still between scans
    initial {tck, tdi, chainSelect, captureDr, shiftDr, updateDr} = 6'h00;
    // State held 5 cycles either side of the rise, beyond the sync delay
    task automatic tick(input logic c, input logic s, input logic u, input logic d);
        {chainSelect, captureDr, shiftDr, updateDr} <= {1'b1, c, s, u};
        tdi <= s ? d : ~tdi;
        repeat (5) @(posedge clk_sys);
        tck <= 1'b1;
        repeat (5) @(posedge clk_sys);
        tck <= 1'b0;
    endtask
    task automatic scan(input logic [15:0] w, output logic [15:0] cap);
        tick(1'b1, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 16; i++) begin
            cap[i] = tdo;
            tick(1'b0, 1'b1, 1'b0, w[i]);
        end
        tick(1'b0, 1'b0, 1'b1, 1'b0);
        @(posedge clk_sys);
        {chainSelect, captureDr, shiftDr, updateDr} <= 4'h0;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire
